/* hw/snp_regs.vh */
`ifndef SNP_REGS_VH
`define SNP_REGS_VH
`define SNP_CLK_HZ   100000000
`define SNP_MS_CYC   32'h000186A0
`define SNP_A_CTRL   8'h00
`define SNP_A_MATCH  8'h04
`define SNP_A_GAP    8'h08
`define SNP_A_STAT   8'h0C
`define SNP_CTRL_RST 32'h00050300
`define SNP_MATCH_RST 32'h00000000
`define SNP_GAP_RST  32'h0000000C
`define SNP_C_DIS    0
`define SNP_C_PACK   1
`define SNP_C_ALT    2
`define SNP_C_M2     3
`define SNP_C_FRAME  4
`define SNP_C_PAR    5
`define SNP_C_ODD    6
`define SNP_C_STOP2  7
`define SNP_C_DBITS  9:8
`define SNP_C_TRAIL  15:12
`define SNP_C_BAUD   19:16
`define SNP_C_FI_ACT 20
`define SNP_C_FI_PAS 21
`define SNP_C_FI_CLS 22
`define SNP_C_FO_ACT 23
`define SNP_C_FO_PAS 24
`define SNP_C_FO_CLS 25
`define SNP_M_B1     7:0
`define SNP_M_B2     15:8
`define SNP_G_MS     7:0
`define SNP_S_CNT    4:0
`define SNP_S_PERR   8
`define SNP_S_FERR   9
`define SNP_S_OVR    10
`define SNP_STD_THR  5'h08
`define SNP_DEPTH    5'h10
`define SNP_RESP_OK  2'h0
`define SNP_RESP_ERR 2'h2
`define SNP_B300     300
`define SNP_B600     600
`define SNP_B1200    1200
`define SNP_B2400    2400
`define SNP_B4800    4800
`define SNP_B9600    9600
`define SNP_B19200   19200
`define SNP_B38400   38400
`define SNP_B57600   57600
`define SNP_B115200  115200
`define SNP_B230400  230400
`define SNP_B460800  460800
`define SNP_B921600  921600
`endif

/* hw/snp_top.v */
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`include "snp_regs.vh"

module snp_fifo #(
    parameter W  = 8,
    parameter D  = 16,
    parameter AW = 4
) (
    input  wire          clock_i,
    input  wire          reset_i,
    input  wire          ce_i,
    input  wire          flush_i,
    input  wire          in_valid_i,
    output wire          in_ready_o,
    input  wire [W-1:0]  in_data_i,
    output wire          out_valid_o,
    input  wire          out_ready_i,
    output wire [W-1:0]  out_data_o,
    output wire [AW:0]   count_o
);
    reg [W-1:0]  mem_reg [0:D-1];
    reg [AW-1:0] wp_reg;
    reg [AW-1:0] rp_reg;
    reg [AW:0]   cnt_reg;
    wire         push = in_valid_i && in_ready_o;
    wire         pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (cnt_reg != D[AW:0]);
    assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
    assign out_data_o  = mem_reg[rp_reg];
    assign count_o     = cnt_reg;

    always @(posedge clock_i) begin
        if (reset_i || (ce_i && flush_i)) begin
            wp_reg  <= {AW{1'b0}};
            rp_reg  <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else if (ce_i) begin
            if (push) begin
                mem_reg[wp_reg] <= in_data_i;
                wp_reg          <= wp_reg + 1'b1;
            end
            if (pop)
                rp_reg <= rp_reg + 1'b1;
            cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// Behaviour
// - On the first channel a control bit stops all serial traffic.
// - Baud is 300 to 921600 in the listed steps, 9600 after reset.
// - The data bit count serves transmitter and receiver alike.
// - Parity is configurable and off after reset.
// - Each character ends with its stop bits after data and parity.
// - With packing on, a standard or alternate close policy applies.
// - A pending packet is sent after the gap time of idle input, 12 ms by default.
// - In two-byte mode a group ends only on both match bytes in order.
// - A match byte of 00 disables matching.
// - With matching on, the frame-only bit stops the idle gap from closing a packet.
// - After a match the set number of trailing bytes joins the packet.
// - The input buffer flushes on active open, passive open and close if enabled.
// - The output buffer flushes on the same three events if enabled.
module snp_top #(
    parameter       FIRST_CHAN = 1,
    parameter [31:0] MS_CYCLES = `SNP_MS_CYC
) (
    input  wire        clock_i,
    input  wire        reset_i,
    input  wire        ce_i,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        rxd_i,
    output wire        txd_o,
    input  wire        conn_active_i,
    input  wire        conn_passive_i,
    input  wire        conn_close_i,
    output wire [7:0]  net_data_o,
    output wire        net_last_o,
    output wire        net_valid_o,
    input  wire        net_ready_i,
    input  wire [7:0]  net_in_data_i,
    input  wire        net_in_valid_i,
    output wire        net_in_ready_o
);
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_START = 3'h1;
    localparam [2:0] S_DATA  = 3'h2;
    localparam [2:0] S_PAR   = 3'h3;
    localparam [2:0] S_STOP  = 3'h4;

    function [18:0] baud_div;
        input [3:0] sel;
        reg [31:0] b;
        begin
            case (sel)
                4'h0: b = `SNP_B300;
                4'h1: b = `SNP_B600;
                4'h2: b = `SNP_B1200;
                4'h3: b = `SNP_B2400;
                4'h4: b = `SNP_B4800;
                4'h6: b = `SNP_B19200;
                4'h7: b = `SNP_B38400;
                4'h8: b = `SNP_B57600;
                4'h9: b = `SNP_B115200;
                4'hA: b = `SNP_B230400;
                4'hB: b = `SNP_B460800;
                4'hC: b = `SNP_B921600;
                default: b = `SNP_B9600;
            endcase
            b = `SNP_CLK_HZ / b;
            baud_div = b[18:0];
        end
    endfunction

    function [7:0] dmask;
        input [1:0] code;
        begin
            dmask = 8'hFF >> (2'h3 - code);
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] d;
        input [3:0]  s;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (s[i])
                    merge[i*8 +: 8] = d[i*8 +: 8];
        end
    endfunction

    reg [31:0] ctrl_reg, match_reg, gap_reg;
    reg        awrdy_reg, wrdy_reg, bvalid_reg, arrdy_reg, rvalid_reg;
    reg        awf_reg, wf_reg;
    reg [7:0]  awa_reg;
    reg [31:0] wd_reg, rdata_reg;
    reg [3:0]  ws_reg;
    reg [1:0]  bresp_reg, rresp_reg;
    reg        perr_reg, ferr_reg, ovr_reg;

    wire [18:0] div   = baud_div(ctrl_reg[`SNP_C_BAUD]);
    wire [1:0]  dbits = ctrl_reg[`SNP_C_DBITS];
    wire        dis   = (FIRST_CHAN != 0) && ctrl_reg[`SNP_C_DIS];
    wire [4:0]  in_cnt;

    wire aw_ok = (awa_reg == `SNP_A_CTRL) || (awa_reg == `SNP_A_MATCH) ||
                 (awa_reg == `SNP_A_GAP);
    wire [31:0] status = {21'h0, ovr_reg, ferr_reg, perr_reg, 3'h0, in_cnt};

    always @(posedge clock_i) begin
        if (reset_i) begin
            ctrl_reg   <= `SNP_CTRL_RST;
            match_reg  <= `SNP_MATCH_RST;
            gap_reg    <= `SNP_GAP_RST;
            awrdy_reg  <= 1'b0;
            wrdy_reg   <= 1'b0;
            awf_reg    <= 1'b0;
            wf_reg     <= 1'b0;
            bvalid_reg <= 1'b0;
            arrdy_reg  <= 1'b0;
            rvalid_reg <= 1'b0;
            awa_reg    <= 8'h00;
            wd_reg     <= 32'h0;
            ws_reg     <= 4'h0;
            bresp_reg  <= `SNP_RESP_OK;
            rresp_reg  <= `SNP_RESP_OK;
            rdata_reg  <= 32'h0;
        end else if (ce_i) begin
            if (!awf_reg && !bvalid_reg)
                awrdy_reg <= 1'b1;
            if (!wf_reg && !bvalid_reg)
                wrdy_reg <= 1'b1;
            if (awrdy_reg && s_axi_awvalid) begin
                awrdy_reg <= 1'b0;
                awf_reg   <= 1'b1;
                awa_reg   <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (wrdy_reg && s_axi_wvalid) begin
                wrdy_reg <= 1'b0;
                wf_reg   <= 1'b1;
                wd_reg   <= s_axi_wdata;
                ws_reg   <= s_axi_wstrb;
            end
            if (awf_reg && wf_reg && !bvalid_reg) begin
                awf_reg    <= 1'b0;
                wf_reg     <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg  <= aw_ok ? `SNP_RESP_OK : `SNP_RESP_ERR;
                if (awa_reg == `SNP_A_CTRL)
                    ctrl_reg <= merge(ctrl_reg, wd_reg, ws_reg);
                if (awa_reg == `SNP_A_MATCH)
                    match_reg <= merge(match_reg, wd_reg, ws_reg);
                if (awa_reg == `SNP_A_GAP)
                    gap_reg <= merge(gap_reg, wd_reg, ws_reg);
            end
            if (bvalid_reg && s_axi_bready)
                bvalid_reg <= 1'b0;
            if (!rvalid_reg && !arrdy_reg)
                arrdy_reg <= 1'b1;
            if (arrdy_reg && s_axi_arvalid) begin
                arrdy_reg  <= 1'b0;
                rvalid_reg <= 1'b1;
                rresp_reg  <= `SNP_RESP_OK;
                case ({s_axi_araddr[7:2], 2'h0})
                    `SNP_A_CTRL:  rdata_reg <= ctrl_reg;
                    `SNP_A_MATCH: rdata_reg <= match_reg;
                    `SNP_A_GAP:   rdata_reg <= gap_reg;
                    `SNP_A_STAT:  rdata_reg <= status;
                    default: begin
                        rdata_reg <= 32'h0;
                        rresp_reg <= `SNP_RESP_ERR;
                    end
                endcase
            end
            if (rvalid_reg && s_axi_rready)
                rvalid_reg <= 1'b0;
        end
    end

    reg        rs1_reg, rs2_reg;
    reg [2:0]  rst_reg;
    reg [18:0] rtm_reg;
    reg [2:0]  rbit_reg;
    reg [7:0]  rsh_reg;
    reg        rstb_reg;
    always @(posedge clock_i) begin
        if (reset_i) begin
            rs1_reg  <= 1'b1;
            rs2_reg  <= 1'b1;
            rst_reg  <= S_IDLE;
            rtm_reg  <= 19'h0;
            rbit_reg <= 3'h0;
            rsh_reg  <= 8'h00;
            rstb_reg <= 1'b0;
            perr_reg <= 1'b0;
            ferr_reg <= 1'b0;
        end else if (ce_i) begin
            rs1_reg  <= rxd_i;
            rs2_reg  <= rs1_reg;
            rstb_reg <= 1'b0;
            if (rtm_reg != 19'h0)
                rtm_reg <= rtm_reg - 19'h1;
            case (rst_reg)
                S_IDLE: if (!rs2_reg && !dis) begin
                    rst_reg <= S_START;
                    rtm_reg <= {1'b0, div[18:1]};
                end
                S_START: if (rtm_reg == 19'h0) begin
                    rst_reg  <= rs2_reg ? S_IDLE : S_DATA;
                    rtm_reg  <= div - 19'h1;
                    rbit_reg <= 3'h0;
                    rsh_reg  <= 8'h00;
                end
                S_DATA: if (rtm_reg == 19'h0) begin
                    rsh_reg[rbit_reg] <= rs2_reg;
                    rbit_reg <= rbit_reg + 3'h1;
                    rtm_reg  <= div - 19'h1;
                    if (rbit_reg == {1'b1, dbits})
                        rst_reg <= ctrl_reg[`SNP_C_PAR] ? S_PAR : S_STOP;
                end
                S_PAR: if (rtm_reg == 19'h0) begin
                    perr_reg <= rs2_reg ^ ctrl_reg[`SNP_C_ODD] ^
                                (^(rsh_reg & dmask(dbits)));
                    rst_reg  <= S_STOP;
                    rtm_reg  <= div - 19'h1;
                end
                S_STOP: if (rtm_reg == 19'h0) begin
                    ferr_reg <= !rs2_reg;
                    rstb_reg <= !dis;
                    rst_reg  <= S_IDLE;
                end
                default: rst_reg <= S_IDLE;
            endcase
        end
    end

    wire        in_rdy, in_vld;
    wire [7:0]  in_q;
    reg  [4:0]  pend_reg, rel_reg;
    reg  [3:0]  trl_reg;
    reg         trla_reg, m1_reg;
    reg  [16:0] pre_reg;
    reg  [7:0]  ms_reg;
    reg  [7:0]  nd_reg;
    reg         nv_reg, nl_reg;
    wire [7:0]  mb1 = match_reg[`SNP_M_B1];
    wire [7:0]  mb2 = match_reg[`SNP_M_B2];
    wire        m2  = ctrl_reg[`SNP_C_M2];
    wire        mon = (mb1 != 8'h00) && (!m2 || mb2 != 8'h00);
    wire        push = rstb_reg && in_rdy;
    wire        hit1 = (rsh_reg == mb1);
    wire        hit  = push && mon && (m2 ? (m1_reg && rsh_reg == mb2) : hit1);
    wire [3:0]  ntrl = ctrl_reg[`SNP_C_TRAIL];
    wire        mcls = (hit && ntrl == 4'h0) ||
                       (push && trla_reg && trl_reg == 4'h1);
    wire [4:0]  pend_p = pend_reg + {4'h0, push};
    wire [4:0]  thr = ctrl_reg[`SNP_C_ALT] ? `SNP_DEPTH : `SNP_STD_THR;
    wire        icls = !rstb_reg && pend_reg != 5'h0 && ms_reg >= gap_reg[`SNP_G_MS] &&
                       !(ctrl_reg[`SNP_C_FRAME] && mon);
    wire        close = !ctrl_reg[`SNP_C_PACK] ? push :
                        (mcls || icls || pend_p >= thr);
    wire        pop = in_vld && rel_reg != 5'h0 && (!nv_reg || net_ready_i);
    wire        fl_in = (conn_active_i && ctrl_reg[`SNP_C_FI_ACT]) ||
                        (conn_passive_i && ctrl_reg[`SNP_C_FI_PAS]) ||
                        (conn_close_i && ctrl_reg[`SNP_C_FI_CLS]);
    wire        fl_out = (conn_active_i && ctrl_reg[`SNP_C_FO_ACT]) ||
                         (conn_passive_i && ctrl_reg[`SNP_C_FO_PAS]) ||
                         (conn_close_i && ctrl_reg[`SNP_C_FO_CLS]);

    snp_fifo #(.W(8), .D(`SNP_DEPTH), .AW(4)) u_in (
        .clock_i     (clock_i),
        .reset_i     (reset_i),
        .ce_i        (ce_i),
        .flush_i     (fl_in),
        .in_valid_i  (rstb_reg),
        .in_ready_o  (in_rdy),
        .in_data_i   (rsh_reg),
        .out_valid_o (in_vld),
        .out_ready_i (pop),
        .out_data_o  (in_q),
        .count_o     (in_cnt)
    );

    always @(posedge clock_i) begin
        if (reset_i || (ce_i && fl_in)) begin
            pend_reg <= 5'h0;
            rel_reg  <= 5'h0;
            trl_reg  <= 4'h0;
            trla_reg <= 1'b0;
            m1_reg   <= 1'b0;
            pre_reg  <= 17'h0;
            ms_reg   <= 8'h00;
            nd_reg   <= 8'h00;
            nv_reg   <= 1'b0;
            nl_reg   <= 1'b0;
            if (reset_i)
                ovr_reg <= 1'b0;
        end else if (ce_i) begin
            if (rstb_reg && !in_rdy)
                ovr_reg <= 1'b1;
            if (push)
                m1_reg <= hit1;
            if (hit && ntrl != 4'h0) begin
                trla_reg <= 1'b1;
                trl_reg  <= ntrl;
            end else if (push && trla_reg) begin
                trl_reg  <= trl_reg - 4'h1;
                trla_reg <= (trl_reg != 4'h1);
            end
            if (close) begin
                pend_reg <= 5'h0;
                trla_reg <= 1'b0;
            end else
                pend_reg <= pend_p;
            rel_reg <= rel_reg - {4'h0, pop} + (close ? pend_p : 5'h0);
            if (rstb_reg || mcls) begin
                pre_reg <= 17'h0;
                ms_reg  <= 8'h00;
            end else if ({15'h0, pre_reg} == MS_CYCLES - 32'h1) begin
                pre_reg <= 17'h0;
                if (ms_reg != 8'hFF)
                    ms_reg <= ms_reg + 8'h01;
            end else
                pre_reg <= pre_reg + 17'h1;
            if (pop) begin
                nd_reg <= in_q;
                nv_reg <= 1'b1;
                nl_reg <= (rel_reg == 5'h1);
            end else if (net_ready_i)
                nv_reg <= 1'b0;
        end
    end

    wire        ob_vld;
    wire [7:0]  ob_q;
    wire [4:0]  ob_cnt;
    reg         nrdy_reg, txd_reg, stp_reg, tpar_reg;
    reg  [2:0]  tst_reg, tbit_reg;
    reg  [18:0] ttm_reg;
    reg  [7:0]  tsh_reg;
    wire        tpop = (tst_reg == S_IDLE) && ob_vld && !dis;

    snp_fifo #(.W(8), .D(`SNP_DEPTH), .AW(4)) u_out (
        .clock_i     (clock_i),
        .reset_i     (reset_i),
        .ce_i        (ce_i),
        .flush_i     (fl_out),
        .in_valid_i  (net_in_valid_i && nrdy_reg),
        .in_ready_o  (),
        .in_data_i   (net_in_data_i),
        .out_valid_o (ob_vld),
        .out_ready_i (tpop),
        .out_data_o  (ob_q),
        .count_o     (ob_cnt)
    );

    always @(posedge clock_i) begin
        if (reset_i) begin
            nrdy_reg <= 1'b0;
            txd_reg  <= 1'b1;
            tst_reg  <= S_IDLE;
            tbit_reg <= 3'h0;
            ttm_reg  <= 19'h0;
            tsh_reg  <= 8'h00;
            stp_reg  <= 1'b0;
            tpar_reg <= 1'b0;
        end else if (ce_i) begin
            // Ready is registered, so it looks one word ahead.
            nrdy_reg <= (ob_cnt < `SNP_DEPTH - 5'h01) || fl_out;
            if (ttm_reg != 19'h0)
                ttm_reg <= ttm_reg - 19'h1;
            case (tst_reg)
                S_IDLE: if (tpop) begin
                    tsh_reg  <= ob_q & dmask(dbits);
                    tpar_reg <= ctrl_reg[`SNP_C_ODD] ^ (^(ob_q & dmask(dbits)));
                    txd_reg  <= 1'b0;
                    ttm_reg  <= div - 19'h1;
                    tbit_reg <= 3'h0;
                    tst_reg  <= S_START;
                end
                S_START, S_DATA: if (ttm_reg == 19'h0) begin
                    ttm_reg <= div - 19'h1;
                    if (tst_reg == S_DATA && tbit_reg == {1'b1, dbits}) begin
                        tst_reg <= ctrl_reg[`SNP_C_PAR] ? S_PAR : S_STOP;
                        txd_reg <= ctrl_reg[`SNP_C_PAR] ? tpar_reg : 1'b1;
                        stp_reg <= ctrl_reg[`SNP_C_STOP2];
                    end else begin
                        txd_reg  <= tsh_reg[0];
                        tsh_reg  <= {1'b0, tsh_reg[7:1]};
                        tbit_reg <= (tst_reg == S_DATA) ? tbit_reg + 3'h1 : 3'h0;
                        tst_reg  <= S_DATA;
                    end
                end
                S_PAR: if (ttm_reg == 19'h0) begin
                    txd_reg <= 1'b1;
                    ttm_reg <= div - 19'h1;
                    tst_reg <= S_STOP;
                end
                S_STOP: if (ttm_reg == 19'h0) begin
                    stp_reg <= 1'b0;
                    ttm_reg <= div - 19'h1;
                    if (!stp_reg)
                        tst_reg <= S_IDLE;
                end
                default: tst_reg <= S_IDLE;
            endcase
        end
    end

    assign s_axi_awready  = awrdy_reg;
    assign s_axi_wready   = wrdy_reg;
    assign s_axi_bvalid   = bvalid_reg;
    assign s_axi_bresp    = bresp_reg;
    assign s_axi_arready  = arrdy_reg;
    assign s_axi_rvalid   = rvalid_reg;
    assign s_axi_rdata    = rdata_reg;
    assign s_axi_rresp    = rresp_reg;
    assign txd_o          = txd_reg;
    assign net_data_o     = nd_reg;
    assign net_valid_o    = nv_reg;
    assign net_last_o     = nl_reg;
    assign net_in_ready_o = nrdy_reg;
endmodule

/* test/snp_top_props.sv */
`timescale 1ns/100ps
module snp_top_props (
    input wire        clock_i,
    input wire        reset_i,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        txd_o,
    input wire        net_valid_o,
    input wire        net_ready_i,
    input wire        net_last_o,
    input wire [7:0]  net_data_o,
    input wire        net_in_ready_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    chk_b_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("b dropped");
    chk_b_timing: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("b late");
    chk_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*3])
        else $error("aw while busy");
    chk_r_timing: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("r late");
    chk_r_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("r dropped");
    chk_hole_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0F
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("hole read");
    chk_net_held: assert property (net_valid_o && !net_ready_i |=> net_valid_o
        && $stable({net_last_o, net_data_o})) else $error("net word moved");
    chk_bit_width: assert property ($fell(txd_o) |=> !txd_o [*8])
        else $error("short bit");
    chk_reset_idle: assert property (disable iff (1'b0) reset_i |=> !s_axi_awready
        && !s_axi_bvalid && !net_valid_o && txd_o && !net_in_ready_o) else $error("reset busy");
    cover property (net_valid_o && net_ready_i && net_last_o);
    cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
    cover property (!net_in_ready_o);
endmodule
bind snp_top snp_top_props snp_top_props_inst (.*);

/* test/snp_serial_dev.sv */
`timescale 1ns/100ps
module snp_serial_dev #(
    parameter DIV = 108
) (
    input  wire clock_i,
    input  wire txd_i,
    output reg  rxd_o
);
    reg [10:0] frame;
    integer    frames, i, k;
    initial begin
        rxd_o = 1'b1;
        frames = 0;
    end
    task bit_out(input b); begin
        rxd_o <= b;
        repeat (DIV) @(posedge clock_i);
    end endtask
    task send(input [7:0] v, input [3:0] n, input pe, input po); begin
        bit_out(1'b0);
        for (k = 0; k < n; k = k + 1) bit_out(v[k]);
        if (pe) bit_out(^(v & ((8'h01 << n) - 8'h01)) ^ po);
        bit_out(1'b1);
    end endtask
    always begin
        @(negedge txd_i);
        repeat (DIV / 2) @(posedge clock_i);
        for (i = 0; i < 11; i = i + 1) begin
            repeat (DIV) @(posedge clock_i);
            frame[i] = txd_i;
        end
        frames = frames + 1;
    end
endmodule

/* test/serial_to_network_packer_bench.sv */
`timescale 1ns/100ps
`include "snp_regs.vh"
module serial_to_network_packer_bench;
    reg         clock_i, reset_i, ce_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    reg         s_axi_rready, conn_active_i, conn_passive_i, conn_close_i, net_ready_i;
    reg         net_in_valid_i;
    reg  [7:0]  s_axi_awaddr, s_axi_araddr, net_in_data_i;
    reg  [31:0] s_axi_wdata, d;
    reg  [3:0]  s_axi_wstrb;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire        txd_o, rxd_i, net_last_o, net_valid_o, net_in_ready_o;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0]  net_data_o;
    integer     n_fail, checked, cyc, k, w, b, f0;
    logic [8:0] q[$];
    localparam [47:0] PAT = 48'h330A0D220D11;
    snp_top #(.FIRST_CHAN(1), .MS_CYCLES(200)) snp_top_inst (.*);
    snp_serial_dev #(.DIV(108)) snp_serial_dev_inst (.clock_i(clock_i), .txd_i(txd_o),
        .rxd_o(rxd_i));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task wrap_up; begin
        if (n_fail == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    end endtask
    always @(posedge clock_i) begin
        if (net_valid_o && net_ready_i) q.push_back({net_last_o, net_data_o});
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            n_fail = n_fail + 1;
            wrap_up;
        end
    end
    task chk(input [31:0] s, input [31:0] e); begin
        checked = checked + 1;
        if (s !== e) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    end endtask
    task axw(input [7:0] a, input [31:0] v, input [1:0] er); begin
        @(posedge clock_i);
        {s_axi_awaddr, s_axi_wdata} <= {a, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (s_axi_awvalid || s_axi_wvalid) begin
            @(posedge clock_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid) @(posedge clock_i);
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
    end endtask
    task axr(input [7:0] a, input [1:0] er); begin
        @(posedge clock_i);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge clock_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clock_i);
        d = s_axi_rdata;
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
    end endtask
    task push(input [7:0] v); begin
        @(posedge clock_i);
        {net_in_valid_i, net_in_data_i} <= {1'b1, v};
        do @(posedge clock_i); while (!net_in_ready_o);
        net_in_valid_i <= 1'b0;
    end endtask
    task pulse(input [2:0] p); begin
        @(posedge clock_i);
        {conn_active_i, conn_passive_i, conn_close_i} <= p;
        @(posedge clock_i);
        {conn_active_i, conn_passive_i, conn_close_i} <= 3'h0;
    end endtask
    task ser(input [7:0] v); snp_serial_dev_inst.send(v, 8, 0, 0); endtask
    task waitq(input integer n); begin
        for (w = 0; w < 3000 && q.size() < n; w = w + 1) @(posedge clock_i);
    end endtask
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {conn_active_i, conn_passive_i, conn_close_i, net_in_valid_i} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, net_in_data_i, s_axi_wdata} = 56'h0;
        {reset_i, ce_i, net_ready_i, s_axi_wstrb} = 7'h7F;
        {n_fail, checked, cyc} = 96'h0;
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        axr(`SNP_A_CTRL, `SNP_RESP_OK);
        chk(d, `SNP_CTRL_RST);
        axr(`SNP_A_MATCH, `SNP_RESP_OK);
        chk(d, `SNP_MATCH_RST);
        axr(`SNP_A_GAP, `SNP_RESP_OK);
        chk(d, `SNP_GAP_RST);
        axr(8'h10, `SNP_RESP_ERR);
        axw(`SNP_A_STAT, 32'hFFFFFFFF, `SNP_RESP_ERR);
        axw(`SNP_A_CTRL, 32'h000C0300, `SNP_RESP_OK);
        ser(8'hA5);
        waitq(1);
        chk(q[0], 9'h1A5);
        axw(`SNP_A_CTRL, 32'h000C0220, `SNP_RESP_OK);
        f0 = snp_serial_dev_inst.frames;
        push(8'h55);
        for (w = 0; w < 2000 && snp_serial_dev_inst.frames == f0; w = w + 1) @(posedge clock_i);
        chk(snp_serial_dev_inst.frame, 32'h755);
        snp_serial_dev_inst.send(8'h2A, 7, 1, 1);
        axr(`SNP_A_STAT, `SNP_RESP_OK);
        chk(d & 32'h300, 32'h100);
        axw(`SNP_A_CTRL, 32'h010C0301, `SNP_RESP_OK);
        for (k = 0; k < 15; k = k + 1) push(k);
        repeat (2) @(posedge clock_i);
        chk(net_in_ready_o, 0);
        b = q.size();
        ser(8'h77);
        chk(q.size(), b);
        pulse(3'h2);
        repeat (2) @(posedge clock_i);
        chk(net_in_ready_o, 1);
        f0 = snp_serial_dev_inst.frames;
        axw(`SNP_A_CTRL, 32'h000C0300, `SNP_RESP_OK);
        repeat (1500) @(posedge clock_i);
        chk(snp_serial_dev_inst.frames, f0);
        net_ready_i <= 1'b0;
        b = q.size();
        for (k = 0; k < 18; k = k + 1) ser(k);
        axr(`SNP_A_STAT, `SNP_RESP_OK);
        chk(d & 32'h41F, 32'h410);
        net_ready_i <= 1'b1;
        waitq(b + 17);
        repeat (20) @(posedge clock_i);
        chk(q.size(), b + 17);
        axw(`SNP_A_CTRL, 32'h000C0302, `SNP_RESP_OK);
        q.delete();
        for (k = 0; k < 3; k = k + 1) ser(k);
        repeat (1500) @(posedge clock_i);
        chk(q.size(), 0);
        repeat (1500) @(posedge clock_i);
        chk(q.size(), 3);
        chk(q[0], 9'h000);
        chk(q[2], 9'h102);
        axw(`SNP_A_MATCH, 32'h00000A0D, `SNP_RESP_OK);
        axw(`SNP_A_CTRL, 32'h000C130A, `SNP_RESP_OK);
        q.delete();
        for (k = 0; k < 6; k = k + 1) ser(PAT[8*k+:8]);
        repeat (300) @(posedge clock_i);
        chk(q.size(), 6);
        chk(q[4], 9'h00A);
        chk(q[5], 9'h133);
        axw(`SNP_A_CTRL, 32'h004C131A, `SNP_RESP_OK);
        q.delete();
        ser(8'h44);
        repeat (3500) @(posedge clock_i);
        chk(q.size(), 0);
        pulse(3'h1);
        for (k = 3; k < 6; k = k + 1) ser(PAT[8*k+:8]);
        repeat (300) @(posedge clock_i);
        chk(q.size(), 3);
        chk(q[0], 9'h00D);
        wrap_up;
    end
endmodule
